// File: pkg/fetch_bus_defs.svh
// constants for the program fetch and external bus block
// assumes a 100 MHz core clock and a 16-bit program address space
//
// Functional notes
// - fetching starts at address zero after reset
// - interrupt vectors fixed, eight bytes apart
// - 4K ROM: below 1000H internal, else external
// - 8K ROM: below 2000H internal, else external
// - 16K ROM: below 4000H internal, else external
// - 32K ROM: below 8000H internal, else external
// - select low sends every fetch external
// - program strobe only for external fetches
// - port zero drives low address, then floats
// - address latch strobe while low address valid
// - port two holds high address throughout fetch
// - program strobe then memory drives code byte
// - program addresses always full 16 bits
// - ports zero and two owned by bus
// - program memory never written
// - separate active-low data read/write strobes
// - data addresses 8-bit or 16-bit pointer
// - two-byte data address: high on port two
`ifndef FETCH_BUS_DEFS_SVH
`define FETCH_BUS_DEFS_SVH

// ---------------------------------------------------------------
// vectors
// ---------------------------------------------------------------
`define VEC_RESET    16'h0000
`define VEC_EXT0     16'h0003
`define VEC_TIMER0   16'h000b
`define VEC_EXT1     16'h0013
`define VEC_TIMER1   16'h001b
`define IRQ_EXT0     4'h1
`define IRQ_TIMER0   4'h2
`define IRQ_EXT1     4'h4
`define IRQ_TIMER1   4'h8

// ---------------------------------------------------------------
// internal rom limits (first external address per size)
// ---------------------------------------------------------------
`define ROM_TOP_4K   16'h1000
`define ROM_TOP_8K   16'h2000
`define ROM_TOP_16K  16'h4000
`define ROM_TOP_32K  16'h8000
`define ROM_SZ_4K    2'h0
`define ROM_SZ_8K    2'h1
`define ROM_SZ_16K   2'h2
`define ROM_SZ_32K   2'h3

// ---------------------------------------------------------------
// bus phase timing, in ns, rounded up to core cycles
// ---------------------------------------------------------------
`define ADDR_NS      20
`define STROBE_NS    40
`define ADDR_CYC     ((`ADDR_NS + 9) / 10)
`define STROBE_CYC   ((`STROBE_NS + 9) / 10)
`define CNT_W        4

`endif

// File: pkg/fetch_bus_pkg.sv
// types for the program fetch and external bus block
// assumes fetch_bus_defs.svh holds the numbers
package fetch_bus_pkg;

    // bus cycle kinds
    typedef enum logic [1:0] {
        OP_FETCH = 2'h0,
        OP_RD    = 2'h1,
        OP_WR    = 2'h2
    } op_t;

    // request from the core
    typedef struct packed {
        op_t         op;      // kind of cycle
        logic        wide;    // data address is 16 bits
        logic [15:0] addr;    // pc or pointer/8-bit address
        logic [7:0]  wdata;   // write data
    } bus_req_t;

    // phases, gray coded along the path
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_FLOAT = 3'h3,
        ST_STRB  = 3'h2,
        ST_DONE  = 3'h6
    } phase_t;

endpackage : fetch_bus_pkg

// File: hw/rom_region.sv
// decides whether a fetch is served by internal rom
// assumes a synchronised select level from the caller
`timescale 1ns/1ps
`default_nettype none
`include "fetch_bus_defs.svh"

module rom_region (
    input  wire logic [15:0] addr,
    input  wire logic [1:0]  rom_size,
    input  wire logic        rom_present,
    input  wire logic        ea_high,
    output logic             internal
);
    logic [15:0] top;  // first external address

    // ---------------------------------------------------------------
    // region decode
    // ---------------------------------------------------------------
    always_comb begin
        case (rom_size)
            `ROM_SZ_4K:  top = `ROM_TOP_4K;
            `ROM_SZ_8K:  top = `ROM_TOP_8K;
            `ROM_SZ_16K: top = `ROM_TOP_16K;
            default:     top = `ROM_TOP_32K;
        endcase
        // select low: nothing internal
        internal = ea_high && rom_present && (addr < top);
    end
endmodule : rom_region
`default_nettype wire

// File: hw/fetch_bus.sv
// program fetch and external bus sequencer
// assumes a core issuing one request at a time, latch on the board
`timescale 1ns/1ps
`default_nettype none
`include "fetch_bus_defs.svh"

module fetch_bus #(
    parameter logic [1:0] ROM_SIZE    = `ROM_SZ_4K,
    parameter bit         ROM_PRESENT = 1'b1
) (
    input  wire logic                      MCLK,
    input  wire logic                      RESET,
    input  wire logic                      REQ_VALID,
    output logic                           REQ_READY,
    input  wire fetch_bus_pkg::bus_req_t   REQ,
    output logic                           RSP_VALID,
    output logic [7:0]                     RSP_DATA,
    output logic                           RSP_INTERNAL,
    output logic [15:0]                    ROM_ADDR,
    input  wire logic [7:0]                ROM_DATA,
    input  wire logic [3:0]                IRQ_SEL,
    output logic [15:0]                    VECTOR,
    output logic [15:0]                    RESET_PC,
    input  wire logic                      EXTERNAL_ACCESS_SELECT_N,
    output logic                           ALE,
    output logic                           PROGRAM_STORE_STROBE_N,
    output logic                           DATA_READ_N,
    output logic                           DATA_WRITE_N,
    input  wire logic [7:0]                PORT_ZERO_ADDR_DATA_I,
    output logic [7:0]                     PORT_ZERO_ADDR_DATA_O,
    output logic                           PORT_ZERO_ADDR_DATA_OE_N,
    output logic [7:0]                     PORT_TWO_HIGH_ADDR,
    output logic                           BUS_OWNED
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    fetch_bus_pkg::phase_t   phase_q;     // bus phase
    fetch_bus_pkg::bus_req_t req_q;       // captured request
    logic [`CNT_W-1:0]       cnt_q;       // cycles left in phase
    logic [1:0]              ea_sync_q;   // select synchroniser
    logic [7:0]              p0_sync0_q;  // port zero first stage
    logic [7:0]              p0_sync1_q;  // port zero second stage
    logic                    ea_high;     // strap level, synced
    logic                    internal;    // served by on-chip rom
    logic                    take;        // request accepted
    logic                    is_fetch;    // request is a fetch
    logic [7:0]              p2_q;        // high address latch
    logic [7:0]              p0o_q;       // port zero drive value
    logic                    p0oe_n_q;    // port zero enable, low=drive
    logic                    ale_q;
    logic                    program_store_strobe_n_n_q;
    logic                    rd_n_q;
    logic                    wr_n_q;
    logic                    rsp_q;
    logic [7:0]              rdata_q;
    logic                    rint_q;

    // ---------------------------------------------------------------
    // strap and data-pin synchronisers
    // ---------------------------------------------------------------
    // strap is active low in name; pin high means rom may serve
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ea_sync_q <= 2'h0;
        end else begin
            ea_sync_q <= {ea_sync_q[0], EXTERNAL_ACCESS_SELECT_N};
        end
    end
    assign ea_high = ea_sync_q[1];

    // port zero sampled through two stages before use
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            p0_sync0_q <= 8'h00;
            p0_sync1_q <= 8'h00;
        end else begin
            p0_sync0_q <= PORT_ZERO_ADDR_DATA_I;
            p0_sync1_q <= p0_sync0_q;
        end
    end

    // ---------------------------------------------------------------
    // region decode
    // ---------------------------------------------------------------
    rom_region u_region (
        .addr        (REQ.addr),
        .rom_size    (ROM_SIZE),
        .rom_present (ROM_PRESENT),
        .ea_high     (ea_high),
        .internal    (internal)
    );

    // ---------------------------------------------------------------
    // vectors, fixed constants
    // ---------------------------------------------------------------
    always_comb begin
        case (IRQ_SEL)
            `IRQ_EXT0:   VECTOR = `VEC_EXT0;
            `IRQ_TIMER0: VECTOR = `VEC_TIMER0;
            `IRQ_EXT1:   VECTOR = `VEC_EXT1;
            `IRQ_TIMER1: VECTOR = `VEC_TIMER1;
            default: VECTOR = `VEC_RESET;
        endcase
    end
    // core loads this pc when reset releases
    assign RESET_PC = `VEC_RESET;

    assign is_fetch  = (REQ.op == fetch_bus_pkg::OP_FETCH);
    assign REQ_READY = (phase_q == fetch_bus_pkg::ST_IDLE);
    assign take      = REQ_VALID && REQ_READY;
    // full 16-bit address to rom, no truncation for small parts
    assign ROM_ADDR  = REQ.addr;

    // ---------------------------------------------------------------
    // phase sequencer
    // ---------------------------------------------------------------
    // a write op is never a fetch, so program space stays read-only
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            phase_q <= fetch_bus_pkg::ST_IDLE;
            cnt_q   <= '0;
            req_q   <= '0;
        end else begin
            case (phase_q)
                fetch_bus_pkg::ST_IDLE: begin
                    if (take && !(is_fetch && internal)) begin
                        req_q   <= REQ;
                        phase_q <= fetch_bus_pkg::ST_ADDR;
                        cnt_q   <= `CNT_W'(`ADDR_CYC - 1);
                    end
                end
                fetch_bus_pkg::ST_ADDR: begin
                    if (cnt_q == '0) begin
                        phase_q <= fetch_bus_pkg::ST_FLOAT;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                fetch_bus_pkg::ST_FLOAT: begin
                    // one cycle with port zero released, or still driving write data for a write
                    phase_q <= fetch_bus_pkg::ST_STRB;
                    cnt_q   <= `CNT_W'(`STROBE_CYC - 1);
                end
                fetch_bus_pkg::ST_STRB: begin
                    if (cnt_q == '0) begin
                        phase_q <= fetch_bus_pkg::ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                fetch_bus_pkg::ST_DONE: begin
                    phase_q <= fetch_bus_pkg::ST_IDLE;
                end
                default: begin
                    phase_q <= fetch_bus_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // pin drive
    // ---------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ale_q    <= 1'b0;
            p0o_q    <= 8'h00;
            p0oe_n_q <= 1'b1;
            p2_q     <= 8'h00;
        end else begin
            ale_q <= 1'b0;
            if (phase_q == fetch_bus_pkg::ST_IDLE && take &&
                !(is_fetch && internal)) begin
                // low byte out, latch strobe high
                p0o_q    <= REQ.addr[7:0];
                p0oe_n_q <= 1'b0;
                ale_q    <= 1'b1;
                // 8-bit data address leaves port two alone
                if (is_fetch || REQ.wide) begin
                    p2_q <= REQ.addr[15:8];
                end
            end else if (phase_q == fetch_bus_pkg::ST_ADDR) begin
                ale_q <= (cnt_q != '0);
                if (cnt_q == '0) begin
                    // float, or put write data out
                    if (req_q.op == fetch_bus_pkg::OP_WR) begin
                        p0o_q <= req_q.wdata;
                    end else begin
                        p0oe_n_q <= 1'b1;
                    end
                end
            end else if (phase_q == fetch_bus_pkg::ST_DONE) begin
                p0oe_n_q <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // strobes
    // ---------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            program_store_strobe_n_n_q <= 1'b1;
            rd_n_q   <= 1'b1;
            wr_n_q   <= 1'b1;
        end else begin
            program_store_strobe_n_n_q <= 1'b1;
            rd_n_q   <= 1'b1;
            wr_n_q   <= 1'b1;
            if (phase_q == fetch_bus_pkg::ST_FLOAT ||
                (phase_q == fetch_bus_pkg::ST_STRB && cnt_q != '0)) begin
                case (req_q.op)
                    fetch_bus_pkg::OP_FETCH: program_store_strobe_n_n_q <= 1'b0;
                    fetch_bus_pkg::OP_RD:    rd_n_q   <= 1'b0;
                    fetch_bus_pkg::OP_WR:    wr_n_q   <= 1'b0;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // answer
    // ---------------------------------------------------------------
    // external byte taken in done from the second sync stage: the wire level one edge before the strobe rose
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            rsp_q   <= 1'b0;
            rdata_q <= 8'h00;
            rint_q  <= 1'b0;
        end else begin
            rsp_q <= 1'b0;
            if (take && is_fetch && internal) begin
                rsp_q   <= 1'b1;
                rdata_q <= ROM_DATA;
                rint_q  <= 1'b1;
            end else if (phase_q == fetch_bus_pkg::ST_DONE) begin
                rsp_q  <= 1'b1;
                rint_q <= 1'b0;
                if (req_q.op != fetch_bus_pkg::OP_WR) begin
                    rdata_q <= p0_sync1_q;
                end
            end
        end
    end

    assign RSP_VALID                = rsp_q;
    assign RSP_DATA                 = rdata_q;
    assign RSP_INTERNAL             = rint_q;
    assign ALE                      = ale_q;
    assign PROGRAM_STORE_STROBE_N   = program_store_strobe_n_n_q;
    assign DATA_READ_N              = rd_n_q;
    assign DATA_WRITE_N             = wr_n_q;
    assign PORT_ZERO_ADDR_DATA_O    = p0o_q;
    assign PORT_ZERO_ADDR_DATA_OE_N = p0oe_n_q;
    assign PORT_TWO_HIGH_ADDR       = p2_q;
    // ports handed to the bus while any external cycle runs
    assign BUS_OWNED = (phase_q != fetch_bus_pkg::ST_IDLE);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_program_store_strobe_n_only_fetch: assert property (@(posedge MCLK) disable iff (RESET)
        !PROGRAM_STORE_STROBE_N |-> (req_q.op == fetch_bus_pkg::OP_FETCH))
        else $error("program strobe on non-fetch");
    a_int_no_program_store_strobe_n: assert property (@(posedge MCLK) disable iff (RESET)
        (take && is_fetch && internal) |-> ##1 PROGRAM_STORE_STROBE_N[*3])
        else $error("program strobe on internal fetch");
    a_ea_low_ext: assert property (@(posedge MCLK) disable iff (RESET)
        (!ea_high && take) |-> ##1 BUS_OWNED)
        else $error("fetch stayed internal with select low");
    a_float_strobe: assert property (@(posedge MCLK) disable iff (RESET)
        !PROGRAM_STORE_STROBE_N |-> PORT_ZERO_ADDR_DATA_OE_N)
        else $error("port zero driven under program strobe");
    a_ale_addr: assert property (@(posedge MCLK) disable iff (RESET)
        ALE |-> (!PORT_ZERO_ADDR_DATA_OE_N &&
                 PORT_ZERO_ADDR_DATA_O == req_q.addr[7:0]))
        else $error("latch strobe without low address");
    a_p2_high: assert property (@(posedge MCLK) disable iff (RESET)
        !PROGRAM_STORE_STROBE_N |-> PORT_TWO_HIGH_ADDR == req_q.addr[15:8])
        else $error("port two not high address");
    a_no_dual_strb: assert property (@(posedge MCLK) disable iff (RESET)
        !(!DATA_READ_N && !DATA_WRITE_N))
        else $error("read and write strobes together");
    a_done_rsp: assert property (@(posedge MCLK) disable iff (RESET)
        (phase_q == fetch_bus_pkg::ST_DONE) |=> RSP_VALID)
        else $error("no answer after external cycle");
    a_cycle_len: assert property (@(posedge MCLK) disable iff (RESET)
        $rose(ALE) |-> ##[1:12] (phase_q == fetch_bus_pkg::ST_DONE))
        else $error("external cycle too long");

endmodule : fetch_bus
`default_nettype wire

// File: bench/ext_mem.sv
// far-side model: address latch, a fixed code pattern and a 256-byte data memory
// assumes a single fetch_bus drives the strobes, latch and port pins
`timescale 1ns/1ps
`default_nettype none

module ext_mem (
    input  wire logic       clk,
    input  wire logic       ale,
    input  wire logic       program_store_strobe_n_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] p0_o,
    input  wire logic       p0_oe_n,
    input  wire logic [7:0] p2,
    output logic      [7:0] p0_i
);
    // ---------------------------------------------------------------
    // latch and memory
    // ---------------------------------------------------------------
    logic [7:0] lo_q;          // latched low address
    logic [7:0] ram [0:255];   // data space, paged by low byte only
    logic [7:0] last_q;        // last level seen on the wire
    logic       hold_q;        // data held one cycle past the strobe
    logic       code_q;        // last strobe was a code fetch
    logic       rd_all_n;      // board gate joining both read strobes
    logic       sel_code;      // offer code byte rather than data
    logic [7:0] out;           // byte offered to the wire

    assign rd_all_n = rd_n & program_store_strobe_n_n;
    assign sel_code = rd_all_n ? code_q : ~program_store_strobe_n_n;
    // code pattern differs from the internal rom so a misroute shows
    assign out = sel_code ? (lo_q ^ p2 ^ 8'ha5) : ram[lo_q];
    // released wire shows the inverse of the last level, never a hold
    assign p0_i = !p0_oe_n ? p0_o :
                  (!rd_all_n || hold_q) ? out : ~last_q;

    // latch sampled on the clock: the strobe and port zero change in
    // one time step, so a level latch could race and grab the wrong byte
    always @(posedge clk) begin
        if (ale && !p0_oe_n) lo_q <= p0_o;
    end

    // wire history, hold window and write capture
    initial {last_q, hold_q, code_q} = '0;
    always @(posedge clk) begin
        last_q <= p0_i;
        hold_q <= ~rd_all_n;
        if (!rd_all_n) code_q <= ~program_store_strobe_n_n;
        if (!wr_n) ram[lo_q] <= p0_o;
    end
endmodule : ext_mem
`default_nettype wire

// File: bench/program_fetch_bus_interface_bench.sv
// bench for fetch_bus: four rom sizes side by side, each with its model
// assumes fetch_bus_defs.svh and fetch_bus_pkg compiled beforehand
`timescale 1ns/1ps
`default_nettype none
`include "fetch_bus_defs.svh"

module program_fetch_bus_interface_bench;
    typedef struct packed {
        logic [1:0]  op;     // 0 fetch, 1 read, 2 write
        logic        wide;   // pointer-wide data address
        logic [15:0] addr;   // request address
        logic [7:0]  wdata;  // write byte
        logic        ea;     // strap pin level
        logic [7:0]  exp;    // expected read byte
    } row_t;

    // ---------------------------------------------------------------
    // stimulus table: boundaries of each rom size, strap low, data
    // ---------------------------------------------------------------
    row_t rows [16] = '{
        '{2'h0,1'b0,16'h0000,8'h00,1'b1,8'h00},
        '{2'h0,1'b0,16'h0fff,8'h00,1'b1,8'h00},
        '{2'h0,1'b0,16'h1000,8'h00,1'b1,8'h00},
        '{2'h0,1'b0,16'h1fff,8'h00,1'b1,8'h00},
        '{2'h0,1'b0,16'h2000,8'h00,1'b1,8'h00},
        '{2'h0,1'b0,16'h3fff,8'h00,1'b1,8'h00},
        '{2'h0,1'b0,16'h4000,8'h00,1'b1,8'h00},
        '{2'h0,1'b0,16'h7fff,8'h00,1'b1,8'h00},
        '{2'h0,1'b0,16'h8000,8'h00,1'b1,8'h00},
        '{2'h0,1'b0,16'hffff,8'h00,1'b1,8'h00},
        '{2'h0,1'b0,16'h0000,8'h00,1'b0,8'h00},
        '{2'h0,1'b0,16'h0fff,8'h00,1'b0,8'h00},
        '{2'h2,1'b0,16'h0042,8'h5e,1'b1,8'h00},
        '{2'h2,1'b1,16'h1281,8'hc7,1'b1,8'h00},
        '{2'h1,1'b0,16'h0042,8'h00,1'b1,8'h5e},
        '{2'h1,1'b1,16'h1281,8'h00,1'b1,8'hc7}};

    logic                    mclk, reset, req_valid, ea, clr;
    fetch_bus_pkg::bus_req_t req;
    logic [3:0]              irq_sel;
    logic [3:0]  ready, rsp_v, rsp_int, ale, program_store_strobe_n_n, rd_n, wr_n, oe_n, own;
    logic [7:0]  rdata [4], p0o [4], p0i [4], p2 [4], rom_data [4];
    logic [15:0] rom_addr [4], vec [4], rpc [4];
    logic [7:0]  lo_s [4], p2_s [4], got [4], lat [4], cyc [4];
    logic [7:0]  pc [4], rc [4], wc [4], clash [4];
    logic        gint [4];
    int          n_errors, compares, cycles;

    for (genvar g = 0; g < 4; g++) begin : sz
        // internal rom pattern, answered in the same cycle
        assign rom_data[g] = rom_addr[g][7:0] ^ rom_addr[g][15:8] ^ 8'h3c;
        fetch_bus #(.ROM_SIZE(2'(g)), .ROM_PRESENT(1'b1)) dut (
            .MCLK(mclk), .RESET(reset), .REQ_VALID(req_valid),
            .REQ_READY(ready[g]), .REQ(req), .RSP_VALID(rsp_v[g]),
            .RSP_DATA(rdata[g]), .RSP_INTERNAL(rsp_int[g]),
            .ROM_ADDR(rom_addr[g]), .ROM_DATA(rom_data[g]),
            .IRQ_SEL(irq_sel), .VECTOR(vec[g]), .RESET_PC(rpc[g]),
            .EXTERNAL_ACCESS_SELECT_N(ea), .ALE(ale[g]),
            .PROGRAM_STORE_STROBE_N(program_store_strobe_n_n[g]), .DATA_READ_N(rd_n[g]),
            .DATA_WRITE_N(wr_n[g]), .PORT_ZERO_ADDR_DATA_I(p0i[g]),
            .PORT_ZERO_ADDR_DATA_O(p0o[g]),
            .PORT_ZERO_ADDR_DATA_OE_N(oe_n[g]),
            .PORT_TWO_HIGH_ADDR(p2[g]), .BUS_OWNED(own[g]));
        ext_mem mem (.clk(mclk), .ale(ale[g]), .program_store_strobe_n_n(program_store_strobe_n_n[g]),
            .rd_n(rd_n[g]), .wr_n(wr_n[g]), .p0_o(p0o[g]),
            .p0_oe_n(oe_n[g]), .p2(p2[g]), .p0_i(p0i[g]));
        // bus watcher: counts strobe cycles, grabs address bytes
        always @(posedge mclk) begin
            cyc[g] <= clr ? 8'h01 : cyc[g] + 8'h01;
            if (clr) begin
                {pc[g], rc[g], wc[g], clash[g]} <= 32'h0;
            end else begin
                if (ale[g] && !oe_n[g]) lo_s[g] <= p0o[g];
                if (!program_store_strobe_n_n[g]) pc[g] <= pc[g] + 8'h01;
                if (!rd_n[g]) rc[g] <= rc[g] + 8'h01;
                if (!wr_n[g]) wc[g] <= wc[g] + 8'h01;
                if (!(program_store_strobe_n_n[g] & rd_n[g] & wr_n[g])) p2_s[g] <= p2[g];
                // driving into a read strobe, or latching without bus
                if ((!(program_store_strobe_n_n[g] & rd_n[g]) && !oe_n[g]) ||
                    (ale[g] && !own[g])) clash[g] <= clash[g] + 8'h01;
            end
            if (rsp_v[g]) begin
                got[g] <= rdata[g];
                gint[g] <= rsp_int[g];
                lat[g] <= cyc[g];
            end
        end
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    always #5 mclk = ~mclk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // strap settles three edges before the request goes out
    task automatic issue(input row_t r);
        @(posedge mclk);
        ea <= r.ea;
        repeat (3) @(posedge mclk);
        req <= '{op: fetch_bus_pkg::op_t'(r.op), wide: r.wide,
                 addr: r.addr, wdata: r.wdata};
        req_valid <= 1'b1;
        clr <= 1'b1;
        @(posedge mclk);
        req_valid <= 1'b0;
        clr <= 1'b0;
    endtask : issue

    task automatic run_row(input row_t r);
        int         k;
        logic       ie;
        logic [7:0] e;
        issue(r);
        #1;
        k = 0;
        while (!(&ready) && k < 20) begin
            @(posedge mclk);
            #1;
            k++;
        end
        @(posedge mclk);
        #1;
        for (int g = 0; g < 4; g++) begin
            ie = r.ea && r.op == 2'h0 && r.addr < (`ROM_TOP_4K << g);
            e = ie ? r.addr[7:0] ^ r.addr[15:8] ^ 8'h3c :
                     r.addr[7:0] ^ r.addr[15:8] ^ 8'ha5;
            check(gint[g], ie);
            check(lat[g], ie ? 16'h1 : 16'h9);
            check(pc[g], (r.op == 2'h0 && !ie) ? 16'h4 : 16'h0);
            check(rc[g], r.op == 2'h1 ? 16'h4 : 16'h0);
            check(wc[g], r.op == 2'h2 ? 16'h4 : 16'h0);
            check(clash[g], 16'h0);
            if (!ie) check(lo_s[g], r.addr[7:0]);
            if (!ie && (r.op == 2'h0 || r.wide))
                check(p2_s[g], r.addr[15:8]);
            if (r.op != 2'h2)
                check(got[g], r.op == 2'h1 ? r.exp : e);
        end
    endtask : run_row

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            give_verdict();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {mclk, req_valid, clr, irq_sel} = '0;
        {reset, ea} = 2'b11;
        req = '0;
        {n_errors, compares, cycles} = '0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        #1;
        check({program_store_strobe_n_n, rd_n, wr_n, oe_n}, 16'hffff);
        check({ale, rsp_v, ready}, 16'h00f);
        check(rpc[0], `VEC_RESET);
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk);
            irq_sel <= (i < 4) ? 4'(1 << i) : 4'h0;
            @(posedge mclk);
            #1;
            check(vec[0], i < 4 ? `VEC_EXT0 + 16'(8 * i) : 16'h0);
        end
        foreach (rows[i]) run_row(rows[i]);
        // reset lands in the middle of an external fetch
        issue(rows[2]);
        repeat (4) @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check({program_store_strobe_n_n, rd_n, wr_n, oe_n}, 16'hffff);
        check({ale, rsp_v, ready}, 16'h00f);
        @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        run_row(rows[2]);
        run_row(rows[0]);
        give_verdict();
    end
endmodule : program_fetch_bus_interface_bench
`default_nettype wire
